// ==== rxlbt_top.sv ====
// Receive link input stage: 32 gapped-clock lanes, priority service, test tap
`include "rxlbt_params.svh"
`timescale 1ns/10ps
module rxlbt_top import rxlbt_pkg::*; #(
  parameter int LANES      = `RXLBT_LANES,
  parameter int FIFO_DEPTH = `RXLBT_FIFO_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic [LANES-1:0]  rx_line_clock,
  input  wire logic [LANES-1:0]  rx_line_data,
  input  wire rxlbt_cfg_t [LANES-1:0] lane_cfg,
  input  wire logic              production_test_select,
  input  wire logic              bert_output_enable,
  input  wire logic [4:0]        bert_lane_select,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output rxlbt_word_t            out_word,
  output logic      [LANES-1:0]  lane_aligned,
  output logic                   rx_bert_data_out,
  output logic                   rx_bert_data_oe,
  output logic                   rx_bert_clock_out,
  output logic                   rx_bert_clock_oe
);

  localparam int WORD_W = $bits(rxlbt_word_t);

  generate
    if (LANES < 1 || LANES > `RXLBT_LANES) begin : g_bad_lanes
      $error("rxlbt_top: LANES must lie between 1 and 32");
    end
    if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("rxlbt_top: FIFO_DEPTH must be at least 2");
    end
    // The gap test halves the period with a fixed slice
    if (`RXLBT_INTERVAL_W != 8) begin : g_bad_interval
      $error("rxlbt_top: interval counters must be 8 bits wide");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Line clocks are sampled, not used as clocks; one sample per
  // phase needs a line clock well below half the system clock, so the
  // top rates of lanes 0..2 need a faster system clock than 100 MHz.
  // At 10 Mbit/s a lane keeps ten system clocks per bit, five per phase.
  logic [LANES-1:0] s_clk;
  logic [LANES-1:0] s_dat;
  logic [6:0]       s_ctl;

  rxlbt_sync #(.WIDTH(2 * LANES)) u_line_sync (
    .clock    (clock),
    .nrst     (rst_n),
    .async_in ({rx_line_clock, rx_line_data}),
    .sync_out ({s_clk, s_dat})
  );

  rxlbt_sync #(.WIDTH(7)) u_ctl_sync (
    .clock    (clock),
    .nrst     (rst_n),
    .async_in ({production_test_select, bert_output_enable, bert_lane_select}),
    .sync_out (s_ctl)
  );

  wire       test_mode = s_ctl[6];
  wire       bert_en   = s_ctl[5];
  wire [4:0] bert_sel  = s_ctl[4:0];
  wire       line_en   = ~test_mode;

  // ----------------------------------------------------------------------
  // Per-lane capture and alignment
  // ----------------------------------------------------------------------
  logic        [LANES-1:0] pend;
  logic        [LANES-1:0] last_bit;
  logic        [LANES-1:0] grant;
  rxlbt_word_t [LANES-1:0] word;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic                         clk_d;
      logic [`RXLBT_INTERVAL_W-1:0] interval;
      logic [`RXLBT_INTERVAL_W-1:0] period;
      logic                         have_period;
      logic [4:0]                   cur_slot;
      logic [2:0]                   cur_bit;
      logic                         aligned;
      logic                         started;

      wire rise    = s_clk[g] & ~clk_d;
      wire chan    = lane_cfg[g].channelised;
      wire e1      = lane_cfg[g].is_e1;
      wire [4:0] first_slot = e1 ? `RXLBT_E1_FIRST_SLOT : `RXLBT_T1_FIRST_SLOT;
      wire [4:0] last_slot  = e1 ? `RXLBT_E1_LAST_SLOT : `RXLBT_T1_LAST_SLOT;

      // A T1 framing gap spans two periods, an E1 slot-0 gap nine
      // A gap is an interval clearly longer than the running bit period
      wire [`RXLBT_INTERVAL_W:0] gap_limit = {1'b0, period} + {2'b00, period[7:1]};
      wire [`RXLBT_INTERVAL_W:0] cur_len   = {1'b0, interval} + 9'h001;
      wire gap      = have_period & (cur_len > gap_limit);
      wire sat      = (interval == `RXLBT_INTERVAL_MAX);

      // Position of the bit taken on this rising edge
      // Counting starts at the first slot on a lane's first edge and after a gap
      wire       restart  = gap | ~started;
      wire [4:0] now_slot = restart ? first_slot : cur_slot;
      wire [2:0] now_bit  = restart ? `RXLBT_RST_BIT : cur_bit;
      wire       slot_end = (now_bit == `RXLBT_BIT_LAST);
      wire       frm_end  = slot_end & (now_slot == last_slot);
      wire [4:0] next_slot = frm_end ? first_slot : (slot_end ? now_slot + 5'h01 : now_slot);
      wire [2:0] next_bit  = now_bit + 3'h1;
      wire       next_aligned = chan & (aligned | gap);

      rxlbt_word_t next_word;
      assign next_word.lane        = 5'(g);
      assign next_word.data        = s_dat[g];
      assign next_word.slot        = chan ? now_slot : `RXLBT_RST_SLOT;
      assign next_word.bit_pos     = chan ? now_bit : `RXLBT_RST_BIT;
      assign next_word.aligned     = chan & next_aligned;
      assign next_word.channelised = chan;
      // Overrun marks a bit that replaced one still waiting for service
      assign next_word.overrun     = pend[g] & ~grant[g];

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          clk_d    <= 1'b0;
          interval <= `RXLBT_RST_INTERVAL;
        end else begin
          clk_d <= s_clk[g];
          if (rise) begin
            interval <= `RXLBT_RST_INTERVAL;
          end else if (!sat) begin
            interval <= interval + 8'h01;
          end
        end
      end

      // Stopped clocks saturate; the next edge then reads as a gap
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          period      <= `RXLBT_RST_INTERVAL;
          have_period <= 1'b0;
        end else if (rise && !gap && !sat) begin
          period      <= interval + 8'h01;
          have_period <= 1'b1;
        end
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cur_slot <= `RXLBT_RST_SLOT;
          cur_bit  <= `RXLBT_RST_BIT;
          aligned  <= 1'b0;
        end else if (!chan || test_mode) begin
          aligned <= 1'b0;
        end else if (rise) begin
          cur_slot <= next_slot;
          cur_bit  <= next_bit;
          aligned  <= next_aligned;
        end
      end

      // Slots are counted from the first edge but not trusted before a gap
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          started <= 1'b0;
        end else if (!chan || test_mode) begin
          started <= 1'b0;
        end else if (rise) begin
          started <= 1'b1;
        end
      end

      // New bit wins over a grant in the same cycle
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pend[g]     <= 1'b0;
          last_bit[g] <= 1'b0;
          word[g]     <= '0;
        end else begin
          if (rise && line_en) begin
            pend[g]     <= 1'b1;
            last_bit[g] <= s_dat[g];
            word[g]     <= next_word;
          end else if (grant[g]) begin
            pend[g] <= 1'b0;
          end
        end
      end

      assign lane_aligned[g] = aligned;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Fixed-priority service
  // ----------------------------------------------------------------------
  // The lowest pending index wins; a busy low lane can starve those above it,
  // which is why fast links belong on low indices.
  logic                   fifo_in_ready;
  logic [LANES-1:0]       first_pend;
  logic [4:0]             win_idx;
  logic [WORD_W-1:0]      fifo_out;

  function automatic logic [4:0] rxlbt_encode(input logic [LANES-1:0] onehot);
    logic [4:0] idx;
    idx = '0;
    for (int i = 0; i < LANES; i++) begin
      if (onehot[i]) idx = 5'(i);
    end
    return idx;
  endfunction : rxlbt_encode

  assign first_pend = pend & (~pend + {{(LANES-1){1'b0}}, 1'b1});
  assign grant      = fifo_in_ready ? first_pend : '0;
  assign win_idx    = rxlbt_encode(first_pend);

  // Back-pressure only holds bits in pend; a second bit then marks overrun
  wire any_pend = |pend;

  // ----------------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------------
  rxlbt_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (any_pend),
    .in_ready  (fifo_in_ready),
    .in_data   (word[win_idx]),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );

  assign out_word = rxlbt_word_t'(fifo_out);

  // ----------------------------------------------------------------------
  // Bit error rate test tap
  // ----------------------------------------------------------------------
  logic bert_clk;
  logic bert_dat;
  logic bert_oe;

  wire sel_clk  = s_clk[bert_sel];
  wire sel_fall = bert_clk & ~sel_clk;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bert_clk <= 1'b0;
      bert_oe  <= 1'b0;
    end else begin
      bert_clk <= sel_clk;
      bert_oe  <= bert_en;
    end
  end

  // Data moves with the registered clock's fall, so it is steady at the rise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bert_dat <= 1'b0;
    end else if (sel_fall) begin
      bert_dat <= last_bit[bert_sel];
    end
  end

  assign rx_bert_clock_out = bert_clk;
  assign rx_bert_clock_oe  = bert_oe;
  assign rx_bert_data_out  = bert_dat;
  assign rx_bert_data_oe   = bert_oe;

endmodule : rxlbt_top

// ==== rxlbt_params.svh ====
// Constants for the receive link input stage and its test tap
`ifndef RXLBT_PARAMS_SVH
`define RXLBT_PARAMS_SVH

// ----------------------------------------------------------------------
// Lane and frame structure
// ----------------------------------------------------------------------
`define RXLBT_LANES          32
`define RXLBT_SEL_W          5
`define RXLBT_SYNC_STAGES    2
`define RXLBT_T1_SLOTS       24
`define RXLBT_E1_SLOTS       31
`define RXLBT_T1_FIRST_SLOT  5'h00
`define RXLBT_T1_LAST_SLOT   5'h17
`define RXLBT_E1_FIRST_SLOT  5'h01
`define RXLBT_E1_LAST_SLOT   5'h1F
`define RXLBT_BIT_LAST       3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RXLBT_CLK_PERIOD_NS  10
`define RXLBT_LOW_RATE_MBPS  10
`define RXLBT_HIGH_RATE_MBPS 52
`define RXLBT_HIGH_LANES     3
`define RXLBT_LOW_BIT_CYC    ((1000 / `RXLBT_LOW_RATE_MBPS) / `RXLBT_CLK_PERIOD_NS)
`define RXLBT_INTERVAL_W     8
`define RXLBT_INTERVAL_MAX   8'hFF

// ----------------------------------------------------------------------
// Reset values and buffering
// ----------------------------------------------------------------------
`define RXLBT_FIFO_DEPTH     8
`define RXLBT_RST_SLOT       5'h00
`define RXLBT_RST_BIT        3'h0
`define RXLBT_RST_INTERVAL   8'h00

`endif

// ==== rxlbt_pkg.sv ====
// Types shared by the receive link input stage
package rxlbt_pkg;

  // Per-lane framing configuration
  typedef struct packed {
    logic channelised;
    logic is_e1;
  } rxlbt_cfg_t;

  // One received bit with its position in the frame
  typedef struct packed {
    logic [4:0] lane;
    logic       data;
    logic [4:0] slot;
    logic [2:0] bit_pos;
    logic       aligned;
    logic       channelised;
    logic       overrun;
  } rxlbt_word_t;

endpackage : rxlbt_pkg

// ==== rxlbt_sync.sv ====
// Two-flop synchroniser for a vector of unrelated levels
`timescale 1ns/10ps
module rxlbt_sync import rxlbt_pkg::*; #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("rxlbt_sync: WIDTH must be at least 1");
    end
  endgenerate

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : rxlbt_sync

// ==== rxlbt_fifo.sv ====
// Word FIFO held in flip-flops, valid and ready on both sides
`timescale 1ns/10ps
module rxlbt_fifo import rxlbt_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
      $error("rxlbt_fifo: DEPTH must be at least 2 and WIDTH at least 1");
    end
  endgenerate

  wire push       = in_valid & in_ready;
  wire pop        = out_valid & out_ready;
  wire wr_wrap    = (wr_ptr == AW'(DEPTH - 1));
  wire rd_wrap    = (rd_ptr == AW'(DEPTH - 1));
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_wrap ? '0 : wr_ptr + AW'(1);
      if (pop)  rd_ptr <= rd_wrap ? '0 : rd_ptr + AW'(1);
      count <= next_count;
    end
  end

  // Storage needs no reset; reads are gated by count
  always_ff @(posedge clock) begin
    if (push) mem[wr_ptr] <= in_data;
  end

endmodule : rxlbt_fifo

// ==== rxlbt_top_properties.sv ====
// Concurrent checks on the ports of the receive link input stage
`timescale 1ns/10ps
module rxlbt_top_props import rxlbt_pkg::*; #(
  parameter int LANES      = 32,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic                   clock,
  input wire logic                   nrst,
  input wire logic [LANES-1:0]       rx_line_clock,
  input wire rxlbt_cfg_t [LANES-1:0] lane_cfg,
  input wire logic                   production_test_select,
  input wire logic                   bert_output_enable,
  input wire logic [4:0]             bert_lane_select,
  input wire logic                   out_valid,
  input wire rxlbt_word_t            out_word,
  input wire logic                   rx_bert_data_out,
  input wire logic                   rx_bert_data_oe,
  input wire logic                   rx_bert_clock_out,
  input wire logic                   rx_bert_clock_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Test tap
  // ----------------------------------------------------------------
  bert_edge_a: assert property ($changed(rx_bert_data_out) |-> $fell(rx_bert_clock_out))
    else $error("test data moved off a test clock fall");
  oe_pair_a: assert property (rx_bert_data_oe == rx_bert_clock_oe)
    else $error("test enables differ");
  oe_on_a: assert property (bert_output_enable [*5] |-> rx_bert_data_oe)
    else $error("test data not driven");
  oe_off_a: assert property (!bert_output_enable [*5] |-> !rx_bert_data_oe)
    else $error("test data not floated");
  clk_rise_a: assert property ($rose(rx_line_clock[bert_lane_select])
    && $stable(bert_lane_select) |-> ##[2:4] rx_bert_clock_out)
    else $error("test clock missed a rise");
  clk_fall_a: assert property ($fell(rx_line_clock[bert_lane_select])
    && $stable(bert_lane_select) |-> ##[2:4] !rx_bert_clock_out)
    else $error("test clock missed a fall");
  // ----------------------------------------------------------------
  // Word stream
  // ----------------------------------------------------------------
  test_quiet_a: assert property (production_test_select [*6] |-> !$rose(out_valid))
    else $error("word produced in test mode");
  unch_word_a: assert property (out_valid && !out_word.channelised |->
    out_word.slot == 5'h00 && out_word.bit_pos == 3'h0 && !out_word.aligned)
    else $error("slot structure on plain lane");
  cfg_mode_a: assert property (out_valid |->
    out_word.channelised == lane_cfg[out_word.lane].channelised)
    else $error("word mode differs from lane mode");
  slot_range_a: assert property (out_valid && out_word.channelised |->
    (lane_cfg[out_word.lane].is_e1 ? out_word.slot >= 5'h01 : out_word.slot <= 5'h17))
    else $error("slot outside frame");
endmodule : rxlbt_top_props

bind rxlbt_top rxlbt_top_props #(.LANES(LANES), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .clock, .nrst, .rx_line_clock, .lane_cfg, .production_test_select,
  .bert_output_enable, .bert_lane_select, .out_valid, .out_word,
  .rx_bert_data_out, .rx_bert_data_oe, .rx_bert_clock_out, .rx_bert_clock_oe);

// ==== rxlbt_line_src.sv ====
// Model of one framer lane: gapped line clock with data
`timescale 1ns/10ps
module rxlbt_line_src #(
  parameter int PERIOD = 80
) (
  input  wire logic       start,
  input  wire logic [7:0] pattern,
  input  wire logic [9:0] nbits,
  output logic            line_clock,
  output logic            line_data,
  output logic            busy
);
  int i;
  initial begin
    line_clock = 1'b0;
    line_data  = 1'b0;
    busy       = 1'b0;
  end
  // Clock stands low between frames; that pause is the gap
  always begin
    @(posedge start);
    busy = 1'b1;
    for (i = 0; i < nbits; i++) begin
      line_data = pattern[7 - i % 8];
      #(PERIOD / 2) line_clock = 1'b1;
      #(PERIOD / 2) line_clock = 1'b0;
    end
    // Stale data would hide a late sample
    line_data = ~line_data;
    busy = 1'b0;
  end
endmodule : rxlbt_line_src

// ==== rxlbt_top_test.sv ====
// Self-checking bench for the receive link input stage
`timescale 1ns/10ps
module rxlbt_top_test import rxlbt_pkg::*;;
  localparam logic [7:0] FPAT = 8'h96;
  logic                clock, nrst, pts, oe, out_ready;
  logic [4:0]          sel;
  logic [31:0]         start;
  wire  [31:0]         line_clk, line_dat, busy;
  logic [7:0]          pattern;
  logic [9:0]          nbits;
  rxlbt_cfg_t [31:0]   cfg;
  logic                out_valid, bd, bdoe, bc, bcoe;
  rxlbt_word_t         out_word;
  logic [31:0]         lane_aligned;
  rxlbt_word_t         got[$];
  int                  err_count, checked, rises;

  rxlbt_top dut_u (.clock(clock), .nrst(nrst), .rx_line_clock(line_clk),
    .rx_line_data(line_dat), .lane_cfg(cfg), .production_test_select(pts),
    .bert_output_enable(oe), .bert_lane_select(sel), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(out_word), .lane_aligned(lane_aligned),
    .rx_bert_data_out(bd), .rx_bert_data_oe(bdoe), .rx_bert_clock_out(bc),
    .rx_bert_clock_oe(bcoe));
  // Fastest lanes sit lowest
  for (genvar g = 0; g < 32; g++) begin : src_g
    rxlbt_line_src #(.PERIOD(g < 3 ? 80 : 100)) src_u (.start(start[g]),
      .pattern(pattern), .nbits(nbits), .line_clock(line_clk[g]),
      .line_data(line_dat[g]), .busy(busy[g]));
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Sampled mid-cycle, ahead of the popping edge
  always @(negedge clock) if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_word);
  always @(posedge bc) rises++;

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic send(input logic [31:0] m, input logic [9:0] n, input logic [7:0] p);
    int w;
    nbits = n;
    pattern = p;
    start = m;
    step(1);
    start = '0;
    for (w = 0; w < 5000 && (busy & m) != 0; w++) step(1);
    chk(busy & m, 32'h0);
    step(8);
  endtask : send
  task automatic t_unch;
    int k;
    got.delete();
    send(32'h0000_0001, 10'h008, 8'hA5);
    chk(got.size(), 8);
    for (k = 0; k < 8; k++) chk(got[k], {5'h00, 1'(8'hA5 >> (7 - k)), 11'h000});
  endtask : t_unch
  task automatic t_frame(input int ln, input logic e1, input int n);
    int k;
    int s;
    rxlbt_word_t w;
    cfg[ln] = '{1'b1, e1};
    got.delete();
    send(32'h0000_0001 << ln, 10'(n * 8 + 8), FPAT);
    chk(got.size(), n * 8 + 8);
    for (k = 0; k < n * 8 + 8; k++) begin
      w = got[k];
      w.aligned = 1'b0;
      s = e1 + (k / 8) % n;
      chk(w, {5'(ln), FPAT[7 - k % 8], 5'(s), 3'(k % 8), 3'b010});
    end
    step(30);
    got.delete();
    send(32'h0000_0001 << ln, 10'h010, FPAT);
    chk(got.size(), 16);
    for (k = 0; k < 16; k++) chk(got[k], {5'(ln), FPAT[7 - k % 8], 5'(e1 + k / 8), 3'(k % 8), 3'b110});
    chk(lane_aligned[ln], 1'b1);
  endtask : t_frame
  task automatic t_prio;
    int k;
    out_ready = 1'b0;
    got.delete();
    send(32'h0000_0007, 10'h001, 8'h80);
    chk(out_valid, 1'b1);
    out_ready = 1'b1;
    step(6);
    chk(got.size(), 3);
    for (k = 0; k < 3; k++) chk(got[k].lane, k);
  endtask : t_prio
  task automatic t_fill;
    int k;
    out_ready = 1'b0;
    got.delete();
    send(32'h0000_0001, 10'h00A, 8'hC3);
    out_ready = 1'b1;
    step(12);
    chk(got.size(), 9);
    for (k = 0; k < 8; k++) chk(got[k], {5'h00, 1'(8'hC3 >> (7 - k)), 11'h000});
    chk(got[8], {5'h00, 1'b1, 11'h001});
  endtask : t_fill
  task automatic t_quiet;
    pts = 1'b1;
    step(4);
    got.delete();
    send(32'h0000_0001, 10'h008, 8'hFF);
    chk(got.size(), 0);
    pts = 1'b0;
    step(4);
  endtask : t_quiet
  task automatic t_bert;
    sel = 5'h03;
    step(6);
    chk({bdoe, bcoe}, 2'b00);
    oe = 1'b1;
    step(6);
    chk({bdoe, bcoe}, 2'b11);
    rises = 0;
    send(32'h0000_0008, 10'h008, 8'h5A);
    chk(bd, 1'b0);
    send(32'h0000_0008, 10'h001, 8'h80);
    chk(bd, 1'b1);
    chk(rises, 9);
    oe = 1'b0;
  endtask : t_bert
  task automatic report_and_stop;
    if (err_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    {nrst, pts, oe, out_ready, sel, start, pattern, nbits} = '0;
    cfg = '0;
    repeat (3) @(posedge clock);
    #1 nrst = 1'b1;
    step(6);
    out_ready = 1'b1;
    t_unch();
    t_frame(1, 1'b0, 24);
    t_frame(2, 1'b1, 31);
    t_prio();
    t_fill();
    t_quiet();
    t_bert();
    report_and_stop();
  end
endmodule : rxlbt_top_test
